// ---- hdl/ppg_engine.sv ----
// pin pulse and pwm engine with per-pin direction and latch bits
`include "ppg_defines.svh"
module ppg_engine
  import ppg_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_n_i,
  // command from interpreter
  input  wire logic                 cmd_valid_i,
  input  wire ppg_pkg::ppg_req_type cmd_i,
  output logic                      cmd_ready_o,
  output logic                      cmd_done_o,
  // direct writes of pin state
  input  wire logic                 pins_we_i,
  input  wire ppg_pkg::ppg_pins_type pins_i,
  // pin drive
  output logic [15:0]               pin_direction_bits_o,
  output logic [15:0]               pin_output_latch_bits_o,
  output logic [15:0]               pin_out_o,
  output logic [15:0]               pin_oe_o
);
  import ppg_pkg::*;

  ppg_state_type state_reg;
  ppg_state_type state_next;
  ppg_req_type   req_reg;
  ppg_req_type   req_next;
  logic [15:0]   dir_reg;
  logic [15:0]   dir_next;
  logic [15:0]   lat_reg;
  logic [15:0]   lat_next;
  logic [15:0]   out_next;
  logic [15:0]   cnt_reg;
  logic [15:0]   cnt_next;
  logic [7:0]    slot_reg;
  logic [7:0]    slot_next;
  logic          ready_next;
  logic          done_next;
  logic          pwm_bit_reg;
  logic          pwm_bit_next;
  logic          unit_tick;
  logic          slot_tick;
  logic          tick_clear;
  logic          dens_clear;
  logic          dens_step;
  logic          dens_bit;

  function automatic logic [15:0] pin_mask(input logic [3:0] p);
    pin_mask = 16'h0001 << p;
  endfunction

  ppg_tick #(
    .DIV (`PPG_UNIT_CYC)
  ) u_unit_tick (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (tick_clear),
    .tick_o    (unit_tick)
  );

  ppg_tick #(
    .DIV (`PPG_SLOT_CYC)
  ) u_slot_tick (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (tick_clear),
    .tick_o    (slot_tick)
  );

  ppg_density u_density (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (dens_clear),
    .step_i    (dens_step),
    .duty_i    (req_next.duty),
    .bit_o     (dens_bit)
  );

  always_comb begin
    state_next   = state_reg;
    req_next     = req_reg;
    dir_next     = dir_reg;
    lat_next     = lat_reg;
    cnt_next     = cnt_reg;
    slot_next    = slot_reg;
    ready_next   = 1'b0;
    done_next    = 1'b0;
    pwm_bit_next = 1'b0;
    tick_clear   = 1'b0;
    dens_clear   = 1'b0;
    dens_step    = slot_tick;
    case (state_reg)
      PPG_IDLE: begin
        ready_next = 1'b1;
        tick_clear = 1'b1;
        dens_clear = 1'b1;
        if (pins_we_i) begin
          dir_next = pins_i.dir;
          lat_next = pins_i.latch;
        end
        if (cmd_valid_i && cmd_ready_o) begin
          ready_next = 1'b0;
          req_next   = cmd_i;
          cnt_next   = cmd_i.count;
          slot_next  = 8'h00;
          // driver on at once, pin shows existing latch bit unless a pwm burst starts, which drives zero this cycle
          dir_next   = dir_next | pin_mask(cmd_i.pin);
          if (cmd_i.cmd == PPG_CMD_PULSE) begin
            state_next = PPG_PREP;
          end else if (cmd_i.count == 16'h0000) begin
            state_next = PPG_FINISH;
          end else begin
            state_next = PPG_PWM;
            // first slot bit formed at the take so no slot is lost
            dens_clear = 1'b0;
            dens_step  = 1'b1;
          end
        end
      end
      PPG_PREP: begin
        // preparation delay counted as two 2 us units
        if (unit_tick) begin
          slot_next = slot_reg + 8'h01;
          if (slot_reg == 8'(`PPG_PREP_NS / `PPG_UNIT_NS - 1)) begin
            lat_next   = lat_reg ^ pin_mask(req_reg.pin);
            state_next = PPG_HOLD;
            tick_clear = 1'b1;
          end
        end
      end
      PPG_HOLD: begin
        if (cnt_reg == 16'h0000) begin
          state_next = PPG_RESTORE;
        end else if (unit_tick) begin
          cnt_next = cnt_reg - 16'h0001;
          if (cnt_reg == 16'h0001) begin
            state_next = PPG_RESTORE;
          end
        end
      end
      PPG_RESTORE: begin
        lat_next   = lat_reg ^ pin_mask(req_reg.pin);
        state_next = PPG_DONE;
      end
      PPG_PWM: begin
        pwm_bit_next = dens_bit;
        if (slot_tick) begin
          if (slot_reg == 8'(`PPG_SLOTS_PER_CYC - 1)) begin
            slot_next = 8'h00;
            cnt_next  = cnt_reg - 16'h0001;
            if (cnt_reg == 16'h0001) begin
              state_next = PPG_FINISH;
            end
          end else begin
            slot_next = slot_reg + 8'h01;
          end
        end
      end
      PPG_FINISH: begin
        dir_next   = dir_reg & ~pin_mask(req_reg.pin);
        state_next = PPG_DONE;
      end
      PPG_DONE: begin
        done_next  = 1'b1;
        ready_next = 1'b1;
        state_next = PPG_IDLE;
      end
      default: begin
        state_next = PPG_IDLE;
      end
    endcase
  end

  // pin drive: pwm overrides the latch while a burst runs
  always_comb begin
    out_next = lat_next;
    if (state_next == PPG_PWM) begin
      out_next = (lat_next & ~pin_mask(req_next.pin))
               | (pwm_bit_next ? pin_mask(req_next.pin) : 16'h0000);
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg               <= PPG_IDLE;
      req_reg                 <= '0;
      dir_reg                 <= `PPG_PIN_RESET;
      lat_reg                 <= `PPG_PIN_RESET;
      cnt_reg                 <= 16'h0000;
      slot_reg                <= 8'h00;
      pwm_bit_reg             <= 1'b0;
      cmd_ready_o             <= 1'b0;
      cmd_done_o              <= 1'b0;
      pin_direction_bits_o    <= `PPG_PIN_RESET;
      pin_output_latch_bits_o <= `PPG_PIN_RESET;
      pin_out_o               <= `PPG_PIN_RESET;
      pin_oe_o                <= `PPG_PIN_RESET;
    end else begin
      state_reg               <= state_next;
      req_reg                 <= req_next;
      dir_reg                 <= dir_next;
      lat_reg                 <= lat_next;
      cnt_reg                 <= cnt_next;
      slot_reg                <= slot_next;
      pwm_bit_reg             <= pwm_bit_next;
      cmd_ready_o             <= ready_next;
      cmd_done_o              <= done_next;
      pin_direction_bits_o    <= dir_next;
      pin_output_latch_bits_o <= lat_next;
      pin_out_o               <= out_next;
      pin_oe_o                <= dir_next;
    end
  end
endmodule

// ---- hdl/ppg_defines.svh ----
// constants for the pin pulse and pwm generator
// Overview of operation
// - Both commands address one of sixteen pins, numbered zero through fifteen.
// - A pulse command first sets the selected pin's direction bit to one.
// - A pulse inverts the latch bit, holds it for the count of 2 us units, then inverts it back.
// - Pulse polarity follows the latch value at command start, zero giving a positive pulse.
// - Enabling the driver shows the latch value at once, and the first inversion waits a few us.
// - After a pulse the pin stays an output driving the restored latch value.
// - During pwm the pin is an output, and at the end its direction bit is cleared.
// - The duty is 8 bits, and the high fraction of the output equals duty divided by 255.
// - The pwm burst length is a 16-bit count of cycles of about one millisecond.
// - Pwm output is a fast train of intervals as short as 4 us whose ratio matches the duty.
// - The pulse duration is a 16-bit count from 0 through 65535 in 2 us units.
// - A pin switched from input to output drives its current latch bit at once; a pwm burst start drives zero on that first cycle instead.
`ifndef PPG_DEFINES_SVH
`define PPG_DEFINES_SVH
`define PPG_CLK_MHZ       100
`define PPG_UNIT_NS       2000
`define PPG_UNIT_CYC      ((`PPG_UNIT_NS * `PPG_CLK_MHZ) / 1000)
`define PPG_PREP_NS       4000
`define PPG_PREP_CYC      ((`PPG_PREP_NS * `PPG_CLK_MHZ) / 1000)
`define PPG_SLOT_NS       4000
`define PPG_SLOT_CYC      ((`PPG_SLOT_NS * `PPG_CLK_MHZ) / 1000)
`define PPG_SLOTS_PER_CYC 255
`define PPG_DUTY_MAX      8'hFF
`define PPG_PIN_RESET     16'h0000
`endif

// ---- hdl/ppg_pkg.sv ----
// types for the pin pulse and pwm generator
package ppg_pkg;
  typedef enum logic [1:0] {
    PPG_CMD_PULSE = 2'b01,
    PPG_CMD_PWM   = 2'b10
  } ppg_cmd_type;

  typedef struct packed {
    ppg_cmd_type cmd;
    logic [3:0]  pin;
    logic [7:0]  duty;
    logic [15:0] count;
  } ppg_req_type;

  typedef struct packed {
    logic [15:0] dir;
    logic [15:0] latch;
  } ppg_pins_type;

  typedef enum logic [2:0] {
    PPG_IDLE    = 3'b000,
    PPG_PREP    = 3'b001,
    PPG_HOLD    = 3'b010,
    PPG_RESTORE = 3'b011,
    PPG_PWM     = 3'b100,
    PPG_FINISH  = 3'b101,
    PPG_DONE    = 3'b110
  } ppg_state_type;
endpackage

// ---- hdl/ppg_tick.sv ----
// free running tick divider
module ppg_tick #(
  parameter int DIV = 200
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  // control
  input  wire logic clear_i,
  output logic      tick_o
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        tick_next;

  always_comb begin
    tick_next = 1'b0;
    cnt_next  = cnt_reg + 16'h0001;
    if (clear_i) begin
      cnt_next = 16'h0000;
    end else if (cnt_reg == 16'(DIV - 1)) begin
      cnt_next  = 16'h0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 16'h0000;
      tick_o  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_o  <= tick_next;
    end
  end
endmodule

// ---- hdl/ppg_density.sv ----
// first order density modulator, one output bit per slot
`include "ppg_defines.svh"
module ppg_density (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  // control
  input  wire logic       clear_i,
  input  wire logic       step_i,
  input  wire logic [7:0] duty_i,
  output logic            bit_o
);
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic       bit_next;
  logic [8:0] sum;

  always_comb begin
    sum      = {1'b0, acc_reg} + {1'b0, duty_i};
    acc_next = acc_reg;
    bit_next = bit_o;
    if (clear_i) begin
      acc_next = 8'h00;
      bit_next = 1'b0;
    end else if (step_i) begin
      // modulus 255: duty of 255 stays high, ratio is duty/255
      if (sum >= {1'b0, `PPG_DUTY_MAX}) begin
        acc_next = 8'(sum - {1'b0, `PPG_DUTY_MAX});
        bit_next = 1'b1;
      end else begin
        acc_next = sum[7:0];
        bit_next = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_reg <= 8'h00;
      bit_o   <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      bit_o   <= bit_next;
    end
  end
endmodule

// ---- tb/ppg_load.sv ----
// external load: pull-up resistor on every pin
module ppg_load (
  // pin drive from the engine
  input  wire logic [15:0] pin_out_i,
  input  wire logic [15:0] pin_oe_i,
  // level seen on the wires
  output logic      [15:0] pin_level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // an undriven pin floats to the pull-up level
  assign pin_level_o = (pin_out_i & pin_oe_i) | ~pin_oe_i;
endmodule

// ---- tb/ppg_engine_monitor.sv ----
// assertion checker for the pulse and pwm engine
module ppg_engine_monitor
  import ppg_pkg::*;
(
  // clock and reset
  input wire logic                 sys_clk_i,
  input wire logic                 reset_n_i,
  // engine ports
  input wire logic                 cmd_valid_i,
  input wire ppg_pkg::ppg_req_type cmd_i,
  input wire logic                 cmd_ready_o,
  input wire logic                 cmd_done_o,
  input wire logic [15:0]          pin_direction_bits_o,
  input wire logic [15:0]          pin_output_latch_bits_o,
  input wire logic [15:0]          pin_out_o,
  input wire logic [15:0]          pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [3:0]  pin_reg;
  logic        pwm_reg;
  logic [15:0] lat_reg;
  logic [23:0] cyc_reg;
  logic [23:0] lim_reg;
  logic        pulse_reg;
  logic        long_reg;
  logic        take;
  assign take = cmd_valid_i && cmd_ready_o;
  // remember the taken command and count cycles since
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_reg <= 4'h0;
      pwm_reg <= 1'b0;
      lat_reg <= 16'h0000;
      cyc_reg <= 24'h000000;
      lim_reg <= 24'h000000;
      pulse_reg <= 1'b0;
      long_reg <= 1'b0;
    end else begin
      cyc_reg <= take ? 24'h000000 : cyc_reg + 24'h000001;
      if (take) begin
        pin_reg <= cmd_i.pin;
        pwm_reg <= cmd_i.cmd != PPG_CMD_PULSE;
        lat_reg <= pin_output_latch_bits_o;
        lim_reg <= {8'h00, cmd_i.count} * 24'h0000C8;
        pulse_reg <= cmd_i.cmd == PPG_CMD_PULSE;
        long_reg <= cmd_i.cmd == PPG_CMD_PULSE && cmd_i.count > 16'h0007;
      end
    end
  end
  sequence pulse_s;
    take && cmd_i.cmd == PPG_CMD_PULSE;
  endsequence
  sequence zero_pwm_s;
    take && cmd_i.cmd != PPG_CMD_PULSE && cmd_i.count == 16'h0000;
  endsequence
  sequence done_pulse_s;
    cmd_done_o && !pwm_reg;
  endsequence
  oe_dir_a: assert property (pin_oe_o == pin_direction_bits_o)
    else $error("enable differs from direction");
  pulse_dir_a: assert property (pulse_s |=> !cmd_ready_o && pin_direction_bits_o[pin_reg])
    else $error("pulse pin not made output");
  prep_hold_a: assert property (pulse_s |=> $stable(pin_output_latch_bits_o) [*8])
    else $error("latch moved during preparation");
  pulse_inv_a: assert property (long_reg && cyc_reg == 24'h000289 |->
    pin_output_latch_bits_o[pin_reg] != lat_reg[pin_reg])
    else $error("latch not inverted during pulse");
  prep_len_a: assert property (pulse_reg && cyc_reg == 24'h00018E |->
    pin_output_latch_bits_o[pin_reg] == lat_reg[pin_reg])
    else $error("latch inverted before preparation ended");
  pulse_len_a: assert property (done_pulse_s |->
    cyc_reg >= lim_reg + 24'h0000C8 && cyc_reg <= lim_reg + 24'h000320)
    else $error("pulse duration off");
  restore_a: assert property (done_pulse_s |->
    pin_output_latch_bits_o == lat_reg && pin_direction_bits_o[pin_reg])
    else $error("latch not restored");
  pwm_off_a: assert property (cmd_done_o && pwm_reg |-> !pin_direction_bits_o[pin_reg])
    else $error("pwm pin left output");
  zero_pwm_a: assert property (zero_pwm_s |-> ##[1:8] cmd_done_o)
    else $error("empty burst not finished");
  done_once_a: assert property (cmd_done_o |-> cmd_ready_o ##1 !cmd_done_o)
    else $error("done not a single pulse");
  idle_drive_a: assert property (cmd_ready_o |-> pin_out_o == pin_output_latch_bits_o)
    else $error("idle drive differs from latch");
endmodule
bind ppg_engine ppg_engine_monitor u_ppg_engine_monitor (
  .sys_clk_i, .reset_n_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .cmd_done_o,
  .pin_direction_bits_o, .pin_output_latch_bits_o, .pin_out_o, .pin_oe_o
);

// ---- tb/ppg_engine_tb.sv ----
// self-checking bench for the pulse and pwm engine
module ppg_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ppg_pkg::*;
  logic         sys_clk, reset_n, cmd_valid, pins_we, cmd_ready, cmd_done;
  ppg_req_type  cmd;
  ppg_pins_type pins;
  logic [15:0]  dir, latch, pout, oe, level;
  logic [31:0]  lfsr_reg = 32'hBC4BA00B;
  int           err_total, tests_run, n;
  int           cyc = 0;
  ppg_engine u_ppg_engine (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .cmd_valid_i(cmd_valid),
    .cmd_i(cmd), .cmd_ready_o(cmd_ready), .cmd_done_o(cmd_done), .pins_we_i(pins_we),
    .pins_i(pins), .pin_direction_bits_o(dir), .pin_output_latch_bits_o(latch),
    .pin_out_o(pout), .pin_oe_o(oe));
  ppg_load u_ppg_load (.pin_out_i(pout), .pin_oe_i(oe), .pin_level_o(level));
  always #5 sys_clk = ~sys_clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // high cycles in a window of 25 slots, and the slack allowed
  function automatic int pwm_expect(input logic [7:0] d);
    return d * 10000 / 255;
  endfunction
  function automatic int pwm_tol(input logic [7:0] d);
    return (d == 8'h00 || d == 8'hFF) ? 0 : 410;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic set_pins(input logic [15:0] d, input logic [15:0] l);
    pins_we <= 1'b1;
    pins <= {d, l};
    @(posedge sys_clk);
    pins_we <= 1'b0;
  endtask
  task automatic send(input ppg_cmd_type c, input logic [3:0] p, input logic [7:0] d,
                      input logic [15:0] c_n);
    int k;
    k = 0;
    cmd_valid <= 1'b1;
    cmd <= '{c, p, d, c_n};
    do begin
      @(posedge sys_clk);
      k++;
    end while (!cmd_ready && k < 50);
    cmd_valid <= 1'b0;
  endtask
  task automatic pulse_test(input logic [3:0] p, input logic [15:0] c_n, input logic lv);
    int w, t;
    logic [15:0] d0, l0;
    lfsr_reg = lfsr_next(lfsr_reg);
    d0 = lfsr_reg[31:16] & ~(16'h0001 << p);
    l0 = lfsr_reg[15:0];
    l0[p] = lv;
    w = 0;
    t = 0;
    set_pins(d0, l0);
    send(PPG_CMD_PULSE, p, lfsr_reg[7:0], c_n);
    pins_we <= 1'b1;
    pins <= '0;
    #1;
    chk("pulse dir", 1, dir[p]);
    chk("prep level", lv, level[p]);
    do begin
      @(posedge sys_clk);
      if (t == 0) pins_we <= 1'b0;
      if (latch[p] !== lv) w++;
      t++;
    end while (!cmd_done && t < 20000);
    chk("pulse width", 1, w + 200 >= c_n * 200 && w <= c_n * 200 + 200);
    chk("restored latch", l0, latch);
    chk("dir kept", d0 | (16'h0001 << p), dir);
    $display("pulse pin %0d count %0d ended", p, c_n);
  endtask
  task automatic pwm_test(input logic [7:0] d);
    int h, lo;
    h = 0;
    lo = 0;
    set_pins(16'h0000, 16'hFFFF);
    send(PPG_CMD_PWM, 4'h7, d, 16'h0001);
    repeat (2) @(posedge sys_clk);
    repeat (10000) begin
      @(posedge sys_clk);
      if (level[7] === 1'b1) h++;
      if (oe[7] !== 1'b1) lo++;
    end
    chk("pwm high", 1, h + pwm_tol(d) >= pwm_expect(d) && h <= pwm_expect(d) + pwm_tol(d));
    chk("pwm drive", 0, lo);
    reset_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk("reset dir", 0, dir);
    $display("pwm duty %0d ended", d);
  endtask
  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    pins_we = 1'b0;
    cmd = '0;
    pins = '0;
    err_total = 0;
    tests_run = 0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    pulse_test(4'h5, 16'h0032, 1'b0);
    pulse_test(4'hF, 16'h0000, 1'b1);
    pulse_test(4'h0, 16'h0001, 1'b0);
    repeat (3) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      pulse_test(lfsr_reg[3:0], {11'h000, lfsr_reg[8:4]}, lfsr_reg[9]);
    end
    for (int i = 0; i < 2; i++) begin
      set_pins(16'hFFFF, 16'hFFFF);
      send(i ? ppg_cmd_type'(2'b11) : PPG_CMD_PWM, 4'(i * 15), 8'h80, 16'h0000);
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (!cmd_done && n < 50);
      chk("empty burst time", 1, n <= 8);
      chk("empty burst dir", 16'hFFFF ^ (16'h0001 << (i * 15)), dir);
      $display("empty burst %0d ended", i);
    end
    pwm_test(8'h00);
    pwm_test(8'hFF);
    pwm_test(8'h64);
    close_out();
  end
endmodule
